// ---- rtl/dcm_pkg.sv ----
package dcm_pkg;
  // group and port shape
  localparam int NGRP = 2;
  localparam int NPORT = 4;
  localparam int PORT_W = 8;
  localparam int DATA_W = NPORT * PORT_W;
  localparam int ADDR_W = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] A_DOUT = 8'h04;
  localparam logic [ADDR_W-1:0] A_DDIR = 8'h08;
  localparam logic [ADDR_W-1:0] A_DIN = 8'h0c;
  localparam logic [ADDR_W-1:0] A_SPARE = 8'h10;
  localparam logic [ADDR_W-1:0] A_STAT = 8'h14;

  // per-group control field, group g starts at g * GRP_STRIDE
  localparam int GRP_STRIDE = 16;
  localparam int CFG_W = 10;
  localparam int F_MODE = 0;
  localparam int MODE_W = 2;
  localparam int F_BURST = 2;
  localparam int F_XFER_IN = 3;
  localparam int F_STRB_OUT = 4;
  localparam int F_START_RISE = 5;
  localparam int F_STOP_RISE = 6;
  localparam int F_PCLK_OVR = 7;
  localparam int F_PCLK_DRV = 8;
  localparam int F_EXCH = 9;

  // spare register: levels, enables, handshake ready
  localparam int SP_OUT = 0;
  localparam int SP_OEN = 4;
  localparam int SP_RDY = 8;
  localparam int SP_W = 10;
  localparam int SP_HI = 2;

  // status register fields
  localparam int ST_RUN = 0;
  localparam int ST_IN = 2;
  localparam int ST_PEER = 6;
  localparam int ST_START = 8;
  localparam int ST_W = 10;

  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] DOUT_RST = 32'h0000_0000;
  localparam logic [NPORT-1:0] DDIR_RST = 4'h0;
  localparam logic [SP_W-1:0] SPARE_RST = 10'h000;

  typedef enum logic [MODE_W-1:0] {DCM_HS, DCM_PAT, DCM_UNS} dcm_mode_t;
  localparam logic [MODE_W-1:0] MODE_MAX = 2'h2;
endpackage

// ---- rtl/dcm_mux.sv ----
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
// What this block does
// - device drives local-ready output in handshake mode
// - pattern strobes on peer-ready, driven or received
// - pattern starts on chosen start-trigger edge
// - pattern ends on chosen stop edge
// - peripheral clock used only in burst handshake
// - clock out on input transfers, overridable
// - unstrobed peer-ready lines are spare inputs three, four
// - unstrobed local-ready lines are spare outputs three, four
// - unstrobed stop lines are spare inputs one, two
// - unstrobed clock lines are spare outputs one, two
// - first data port is port zero
// - second data port is port one
// - exchange swaps local-ready and peer-ready pins
// - third, fourth data ports are two, three
module dcm_mux (
  input wire logic i_clk, // system clock
  input wire logic i_rst_n, // async reset, active low
  input wire logic i_lnk_clk, // link strobe clock
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb enable
  input wire logic i_pwrite, // apb direction
  input wire logic [7:0] i_paddr, // apb byte address
  input wire logic [31:0] i_pwdata, // apb write data
  output logic [31:0] o_prdata, // apb read data
  output logic o_pready, // apb ready
  output logic o_pslverr, // apb error, unmapped
  input wire logic [1:0] i_local_rdy_pin, // local-ready position in
  output logic [1:0] o_local_rdy_pin, // local-ready position out
  output logic [1:0] o_local_rdy_pin_oe, // local-ready position oe
  input wire logic [1:0] i_peer_rdy_pin, // peer-ready position in
  output logic [1:0] o_peer_rdy_pin, // peer-ready position out
  output logic [1:0] o_peer_rdy_pin_oe, // peer-ready position oe
  input wire logic [1:0] i_end_trigger_input, // stop line per group
  input wire logic [1:0] i_periph_clk_pin, // peripheral clock in
  output logic [1:0] o_periph_clk_pin, // peripheral clock out
  output logic [1:0] o_periph_clk_pin_oe, // peripheral clock oe
  input wire logic [7:0] i_data_port_zero, // port 0 in
  output logic [7:0] o_data_port_zero, // port 0 out
  output logic o_data_port_zero_oe, // port 0 oe
  input wire logic [7:0] i_data_port_one, // port 1 in
  output logic [7:0] o_data_port_one, // port 1 out
  output logic o_data_port_one_oe, // port 1 oe
  input wire logic [7:0] i_data_port_two, // port 2 in
  output logic [7:0] o_data_port_two, // port 2 out
  output logic o_data_port_two_oe, // port 2 oe
  input wire logic [7:0] i_data_port_three, // port 3 in
  output logic [7:0] o_data_port_three, // port 3 out
  output logic o_data_port_three_oe // port 3 oe
);
  localparam int G = dcm_pkg::NGRP;
  localparam int DW = dcm_pkg::DATA_W;
  localparam int SW = DW + 5 * G;

  // address decode shared by read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // field value to mode, illegal codes fall back to unstrobed
  function automatic dcm_pkg::dcm_mode_t mode_of(input logic [1:0] f);
    if (f > dcm_pkg::MODE_MAX) begin
      mode_of = dcm_pkg::DCM_UNS;
    end else begin
      mode_of = dcm_pkg::dcm_mode_t'(f);
    end
  endfunction

  logic [31:0] ctrl_q;
  logic [DW-1:0] dout_q;
  logic [dcm_pkg::NPORT-1:0] ddir_q;
  logic [dcm_pkg::SP_W-1:0] spare_q;
  logic [SW-1:0] raw;
  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;
  logic [DW-1:0] din_s;
  logic [G-1:0] loc_s;
  logic [G-1:0] peer_s;
  logic [G-1:0] stop_s;
  logic [G-1:0] pclk_s;
  logic [G-1:0] tgl_s;
  logic [G-1:0] run_q;
  logic [G-1:0] act_q;
  logic [G-1:0] start_in;
  logic [G-1:0] peer_in;
  logic [G-1:0] start_prev_q;
  logic [G-1:0] stop_prev_q;
  logic [3:0] spare_in;
  logic [dcm_pkg::ST_W-1:0] stat;
  logic [G-1:0] lk1_q;
  logic [G-1:0] lk2_q;
  logic [G-1:0] ltgl_q;
  logic wr_en;
  logic setup;

  // every outside pin input except the apb bus passes two flops before use
  assign raw = {ltgl_q, i_periph_clk_pin, i_end_trigger_input,
                i_peer_rdy_pin, i_local_rdy_pin, i_data_port_three,
                i_data_port_two, i_data_port_one, i_data_port_zero};
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end
  assign din_s = s2_q[DW-1:0];
  assign loc_s = s2_q[DW +: G];
  assign peer_s = s2_q[DW + G +: G];
  assign stop_s = s2_q[DW + 2 * G +: G];
  assign pclk_s = s2_q[DW + 3 * G +: G];
  assign tgl_s = s2_q[DW + 4 * G +: G];

  // apb: setup cycle, then one access cycle with pready high
  assign setup = i_psel & ~i_penable;
  assign wr_en = i_psel & i_penable & o_pready & i_pwrite;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= '0;
    end else begin
      o_pready <= setup;
      o_pslverr <= setup & ~(hit(i_paddr, dcm_pkg::A_CTRL) |
                   hit(i_paddr, dcm_pkg::A_DOUT) |
                   hit(i_paddr, dcm_pkg::A_DDIR) |
                   hit(i_paddr, dcm_pkg::A_DIN) |
                   hit(i_paddr, dcm_pkg::A_SPARE) |
                   hit(i_paddr, dcm_pkg::A_STAT));
      o_prdata <= '0;
      if (setup && !i_pwrite) begin
        if (hit(i_paddr, dcm_pkg::A_CTRL)) begin
          o_prdata <= ctrl_q;
        end
        if (hit(i_paddr, dcm_pkg::A_DOUT)) begin
          o_prdata <= dout_q;
        end
        if (hit(i_paddr, dcm_pkg::A_DDIR)) begin
          o_prdata <= 32'(ddir_q);
        end
        if (hit(i_paddr, dcm_pkg::A_DIN)) begin
          o_prdata <= din_s;
        end
        if (hit(i_paddr, dcm_pkg::A_SPARE)) begin
          o_prdata <= 32'(spare_q);
        end
        if (hit(i_paddr, dcm_pkg::A_STAT)) begin
          o_prdata <= 32'(stat);
        end
      end
    end
  end

  // software registers, written at the access edge
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q <= dcm_pkg::CTRL_RST;
      dout_q <= dcm_pkg::DOUT_RST;
      ddir_q <= dcm_pkg::DDIR_RST;
      spare_q <= dcm_pkg::SPARE_RST;
    end else if (wr_en) begin
      if (hit(i_paddr, dcm_pkg::A_CTRL)) begin
        ctrl_q <= i_pwdata;
      end
      if (hit(i_paddr, dcm_pkg::A_DOUT)) begin
        dout_q <= i_pwdata;
      end
      if (hit(i_paddr, dcm_pkg::A_DDIR)) begin
        ddir_q <= i_pwdata[dcm_pkg::NPORT-1:0];
      end
      if (hit(i_paddr, dcm_pkg::A_SPARE)) begin
        spare_q <= i_pwdata[dcm_pkg::SP_W-1:0];
      end
    end
  end

  // data ports: byte n of the data words is port number n
  assign o_data_port_zero = dout_q[0 +: dcm_pkg::PORT_W];
  assign o_data_port_one = dout_q[dcm_pkg::PORT_W +: dcm_pkg::PORT_W];
  assign o_data_port_two = dout_q[2 * dcm_pkg::PORT_W +: dcm_pkg::PORT_W];
  assign o_data_port_three = dout_q[3 * dcm_pkg::PORT_W +: dcm_pkg::PORT_W];
  assign o_data_port_zero_oe = ddir_q[0];
  assign o_data_port_one_oe = ddir_q[1];
  assign o_data_port_two_oe = ddir_q[2];
  assign o_data_port_three_oe = ddir_q[3];

  // status word
  assign stat = {start_in, peer_in, spare_in, run_q};

  // per-group line multiplexing
  for (genvar g = 0; g < G; g++) begin : gen_grp
    localparam int B = g * dcm_pkg::GRP_STRIDE;
    dcm_pkg::dcm_mode_t mode;
    logic exch;
    logic rise_start;
    logic rise_stop;
    logic start_ev;
    logic stop_ev;
    logic loc_o;
    logic loc_oe;
    logic peer_o;
    logic peer_oe;
    logic pc_o;
    logic pc_oe;

    assign mode = mode_of(ctrl_q[B + dcm_pkg::F_MODE +: dcm_pkg::MODE_W]);
    assign exch = ctrl_q[B + dcm_pkg::F_EXCH];
    assign rise_start = ctrl_q[B + dcm_pkg::F_START_RISE];
    assign rise_stop = ctrl_q[B + dcm_pkg::F_STOP_RISE];

    // pick each function from its connector position
    assign start_in[g] = exch ? peer_s[g] : loc_s[g];
    assign peer_in[g] = exch ? loc_s[g] : peer_s[g];

    // spare inputs in unstrobed mode
    assign spare_in[g] = (mode == dcm_pkg::DCM_UNS) & stop_s[g];
    assign spare_in[dcm_pkg::SP_HI + g] =
      (mode == dcm_pkg::DCM_UNS) & peer_in[g];

    // edge detect on synchronised trigger lines
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        start_prev_q[g] <= 1'b0;
        stop_prev_q[g] <= 1'b0;
      end else begin
        start_prev_q[g] <= start_in[g];
        stop_prev_q[g] <= stop_s[g];
      end
    end
    assign start_ev = rise_start ? (start_in[g] & ~start_prev_q[g]) :
                      (~start_in[g] & start_prev_q[g]);
    assign stop_ev = rise_stop ? (stop_s[g] & ~stop_prev_q[g]) :
                     (~stop_s[g] & stop_prev_q[g]);

    // pattern run flag, stop ignored outside pattern mode
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        run_q[g] <= 1'b0;
      end else if (mode != dcm_pkg::DCM_PAT) begin
        run_q[g] <= 1'b0;
      end else if (!run_q[g] && start_ev) begin
        run_q[g] <= 1'b1;
      end else if (run_q[g] && stop_ev) begin
        run_q[g] <= 1'b0;
      end
    end

    // line function and direction from the group mode
    always_comb begin
      loc_o = 1'b0;
      loc_oe = 1'b0;
      peer_o = 1'b0;
      peer_oe = 1'b0;
      pc_o = 1'b0;
      pc_oe = 1'b0;
      unique case (mode)
        dcm_pkg::DCM_HS: begin
          loc_oe = 1'b1;
          loc_o = spare_q[dcm_pkg::SP_RDY + g];
          if (ctrl_q[B + dcm_pkg::F_BURST]) begin
            pc_o = tgl_s[g];
            pc_oe = ctrl_q[B + dcm_pkg::F_PCLK_OVR] ?
                    ctrl_q[B + dcm_pkg::F_PCLK_DRV] :
                    ctrl_q[B + dcm_pkg::F_XFER_IN];
          end
        end
        dcm_pkg::DCM_PAT: begin
          peer_oe = ctrl_q[B + dcm_pkg::F_STRB_OUT];
          peer_o = tgl_s[g];
        end
        dcm_pkg::DCM_UNS: begin
          loc_oe = spare_q[dcm_pkg::SP_OEN + dcm_pkg::SP_HI + g];
          loc_o = spare_q[dcm_pkg::SP_OUT + dcm_pkg::SP_HI + g];
          pc_oe = spare_q[dcm_pkg::SP_OEN + g];
          pc_o = spare_q[dcm_pkg::SP_OUT + g];
        end
      endcase
    end

    // register pins, swapping positions when exchange is set
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        o_local_rdy_pin[g] <= 1'b0;
        o_local_rdy_pin_oe[g] <= 1'b0;
        o_peer_rdy_pin[g] <= 1'b0;
        o_peer_rdy_pin_oe[g] <= 1'b0;
        o_periph_clk_pin[g] <= 1'b0;
        o_periph_clk_pin_oe[g] <= 1'b0;
        act_q[g] <= 1'b0;
      end else begin
        o_local_rdy_pin[g] <= exch ? peer_o : loc_o;
        o_local_rdy_pin_oe[g] <= exch ? peer_oe : loc_oe;
        o_peer_rdy_pin[g] <= exch ? loc_o : peer_o;
        o_peer_rdy_pin_oe[g] <= exch ? loc_oe : peer_oe;
        o_periph_clk_pin[g] <= pc_o;
        o_periph_clk_pin_oe[g] <= pc_oe;
        // strobe generator runs while a driven strobe or clock is needed
        act_q[g] <= (peer_oe & run_q[g]) | (mode == dcm_pkg::DCM_HS & pc_oe);
      end
    end

    // link domain: synchronise enable, toggle strobe each rising link edge
    always_ff @(posedge i_lnk_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        lk1_q[g] <= 1'b0;
        lk2_q[g] <= 1'b0;
        ltgl_q[g] <= 1'b0;
      end else begin
        lk1_q[g] <= act_q[g];
        lk2_q[g] <= lk1_q[g];
        ltgl_q[g] <= lk2_q[g] & ~ltgl_q[g];
      end
    end
  end

  // unused sampled clock input, reduced to unused_pclk and kept out of the status word
  logic unused_pclk;
  assign unused_pclk = ^pclk_s;
endmodule

// ---- verification/dcm_mux_sva.sv ----
`timescale 1ns/1ps
// checks pin directions against a shadow of the written setup
module dcm_mux_sva (
  input wire logic i_clk, // system clock
  input wire logic i_rst_n, // async reset, active low
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb enable
  input wire logic i_pwrite, // apb direction
  input wire logic [7:0] i_paddr, // apb address
  input wire logic [31:0] i_pwdata, // apb write data
  input wire logic o_pready, // apb ready
  input wire logic o_pslverr, // apb error
  input wire logic [1:0] o_local_rdy_pin_oe, // local position enable
  input wire logic [1:0] o_peer_rdy_pin_oe, // peer position enable
  input wire logic [1:0] o_periph_clk_pin_oe, // clock pin enable
  input wire logic o_data_port_zero_oe // port 0 enable
);
  default clocking dcm_cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  logic [31:0] ctl_q;
  logic [7:0] sp_q;
  logic dd_q;
  logic [1:0] calm_q;
  logic wr;
  logic ok;
  logic hs;
  logic pat;
  logic uns;
  // decoded setup of group 0 (unstrobed decode covers both groups), and settled outputs
  assign wr = i_psel && i_penable && i_pwrite && o_pready;
  assign ok = calm_q == 2'h3;
  assign hs = ctl_q[1:0] == 2'h0;
  assign pat = ctl_q[1:0] == 2'h1;
  assign uns = ctl_q[1] && ctl_q[17] && !ctl_q[9] && !ctl_q[25];
  // shadow registers; settle count restarts on every write
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctl_q <= '0;
      sp_q <= '0;
      dd_q <= 1'b0;
      calm_q <= '0;
    end else begin
      if (wr && i_paddr == dcm_pkg::A_CTRL) ctl_q <= i_pwdata;
      if (wr && i_paddr == dcm_pkg::A_SPARE) sp_q <= i_pwdata[7:0];
      if (wr && i_paddr == dcm_pkg::A_DDIR) dd_q <= i_pwdata[0];
      if (wr) calm_q <= '0;
      else if (!ok) calm_q <= calm_q + 2'h1;
    end
  end
  a_ready_after_setup: assert property (
    i_psel && !i_penable |=> o_pready)
    else $error("no ready after setup");
  a_unmapped_err: assert property (
    i_psel && !i_penable && i_paddr > 8'h14 |=> o_pready && o_pslverr)
    else $error("unmapped access not refused");
  a_hs_ready_pos: assert property (
    ok && hs |-> o_local_rdy_pin_oe[0] == !ctl_q[9]
      && o_peer_rdy_pin_oe[0] == ctl_q[9])
    else $error("handshake ready drive misplaced");
  a_pat_lines: assert property (
    ok && pat && !ctl_q[9] |-> !o_local_rdy_pin_oe[0]
      && o_peer_rdy_pin_oe[0] == ctl_q[4])
    else $error("pattern line direction wrong");
  a_clk_unused: assert property (
    ok && !ctl_q[1] && !(hs && ctl_q[2]) |-> !o_periph_clk_pin_oe[0])
    else $error("clock pin driven outside burst");
  a_clk_dir: assert property (
    ok && hs && ctl_q[2] |->
      o_periph_clk_pin_oe[0] == (ctl_q[7] ? ctl_q[8] : ctl_q[3]))
    else $error("burst clock direction wrong");
  a_spare_oe: assert property (
    ok && uns |-> o_periph_clk_pin_oe == sp_q[5:4]
      && o_local_rdy_pin_oe == sp_q[7:6])
    else $error("spare output enables wrong");
  a_port_dir: assert property (
    wr |=> o_data_port_zero_oe == dd_q)
    else $error("port 0 direction wrong");
endmodule
bind dcm_mux dcm_mux_sva dcm_mux_sva_i (.i_clk, .i_rst_n, .i_psel,
  .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_pslverr,
  .o_local_rdy_pin_oe, .o_peer_rdy_pin_oe, .o_periph_clk_pin_oe,
  .o_data_port_zero_oe);

// ---- verification/dcm_periph.sv ----
`timescale 1ns/1ps
// far-side peripheral: drives every line the device leaves released
module dcm_periph (
  input wire logic [1:0] i_dev_lo, // device level, local position
  input wire logic [1:0] i_dev_lo_oe, // device enable, local position
  input wire logic [1:0] i_dev_pe, // device level, peer position
  input wire logic [1:0] i_dev_pe_oe, // device enable, peer position
  input wire logic [1:0] i_dev_ck, // device level, clock pin
  input wire logic [1:0] i_dev_ck_oe, // device enable, clock pin
  input wire logic [31:0] i_dev_d, // device data levels
  input wire logic [3:0] i_dev_d_oe, // device byte enables
  input wire logic [1:0] i_lo, // own start trigger level
  input wire logic [1:0] i_pe, // own request or strobe level
  input wire logic [1:0] i_ck, // own clock level
  input wire logic [31:0] i_d, // own data
  output logic [1:0] o_lo, // local position wire
  output logic [1:0] o_pe, // peer position wire
  output logic [1:0] o_ck, // clock wire
  output logic [31:0] o_d // data wires
);
  // each wire shows whoever drives it
  assign o_pe = (i_dev_pe_oe & i_dev_pe) | (~i_dev_pe_oe & i_pe);
  assign o_lo = (i_dev_lo_oe & i_dev_lo) | (~i_dev_lo_oe & i_lo);
  assign o_ck = (i_dev_ck_oe & i_dev_ck) | (~i_dev_ck_oe & i_ck);
  // data bytes follow the device's per-port enable
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      o_d[8*b +: 8] = i_dev_d_oe[b] ? i_dev_d[8*b +: 8] : i_d[8*b +: 8];
    end
  end
endmodule

// ---- verification/dcm_mux_tb_top.sv ----
`timescale 1ns/1ps
module dcm_mux_tb_top;
  typedef struct packed {
    logic [31:0] ctl;
    logic [9:0] sp;
    logic [9:0] exp;
  } dcm_row_t;
  // setup rows, expected {local oe, peer oe, clock oe, local, clock}
  dcm_row_t rows [8] = '{
    '{32'h0000_0000, 10'h100, 10'h304}, '{32'h0004_000c, 10'h000, 10'h310},
    '{32'h008c_0184, 10'h000, 10'h310}, '{32'h0000_0208, 10'h300, 10'h248},
    '{32'h0001_0011, 10'h000, 10'h040}, '{32'h0002_0002, 10'h0fa, 10'h33a},
    '{32'h0003_0003, 10'h05f, 10'h115}, '{32'h0002_0002, 10'h000, 10'h000}};
  logic clk = 1'b0, lclk = 1'b0, rst_n = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0000_0000, d_dat = 32'h0000_0000, rv;
  logic [1:0] d_lo = 2'h0, d_pe = 2'h0, d_ck = 2'h0, d_stp = 2'h0;
  logic ev;
  wire [31:0] prd, dq, dw;
  wire prdy, perr;
  wire [1:0] lo, lo_oe, pe, pe_oe, ck, ck_oe, lo_w, pe_w, ck_w;
  wire [3:0] doe;
  int fails = 0, n_compared = 0;
  // system clock, and the link clock on its own phase
  always #4 clk = ~clk;
  always #16 lclk = ~lclk;
  dcm_mux dcm_mux_i (.i_clk(clk), .i_rst_n(rst_n), .i_lnk_clk(lclk),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa),
    .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr),
    .i_local_rdy_pin(lo_w), .o_local_rdy_pin(lo), .o_local_rdy_pin_oe(lo_oe),
    .i_peer_rdy_pin(pe_w), .o_peer_rdy_pin(pe), .o_peer_rdy_pin_oe(pe_oe),
    .i_end_trigger_input(d_stp), .i_periph_clk_pin(ck_w),
    .o_periph_clk_pin(ck), .o_periph_clk_pin_oe(ck_oe),
    .i_data_port_zero(dw[7:0]), .o_data_port_zero(dq[7:0]),
    .o_data_port_zero_oe(doe[0]), .i_data_port_one(dw[15:8]),
    .o_data_port_one(dq[15:8]), .o_data_port_one_oe(doe[1]),
    .i_data_port_two(dw[23:16]), .o_data_port_two(dq[23:16]),
    .o_data_port_two_oe(doe[2]), .i_data_port_three(dw[31:24]),
    .o_data_port_three(dq[31:24]), .o_data_port_three_oe(doe[3]));
  dcm_periph dcm_periph_i (.i_dev_lo(lo), .i_dev_lo_oe(lo_oe), .i_dev_pe(pe),
    .i_dev_pe_oe(pe_oe), .i_dev_ck(ck), .i_dev_ck_oe(ck_oe), .i_dev_d(dq),
    .i_dev_d_oe(doe), .i_lo(d_lo), .i_pe(d_pe), .i_ck(d_ck), .i_d(d_dat),
    .o_lo(lo_w), .o_pe(pe_w), .o_ck(ck_w), .o_d(dw));
  task automatic give_verdict();
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until ready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 16);
    rv = prd;
    ev = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (prdy !== 1'b1) begin
      fails++;
      give_verdict();
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rv & m, e);
  endtask
  task automatic wait_run(input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, dcm_pkg::A_STAT, 32'h0000_0000);
      n++;
    end while (rv[0] !== v && n < 10);
    chk(32'(rv[0]), 32'(v));
    if (rv[0] !== v) give_verdict();
  endtask
  initial begin
    int tog;
    logic px;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) rdc(8'(4 * i), 32'hffff_ffff, 32'h0);
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk(rv, 32'h0000_0000);
    chk(32'(ev), 32'h0000_0001);
    foreach (rows[i]) begin
      apb(1'b1, dcm_pkg::A_CTRL, rows[i].ctl);
      apb(1'b1, dcm_pkg::A_SPARE, 32'(rows[i].sp));
      repeat (4) @(posedge clk);
      chk(32'({lo_oe, pe_oe, ck_oe, lo & lo_oe,
        ck & ck_oe & {2{rows[i].ctl[1]}}}), 32'(rows[i].exp));
    end
    apb(1'b1, dcm_pkg::A_DOUT, 32'h4433_2211);
    apb(1'b1, dcm_pkg::A_DDIR, 32'h0000_000f);
    repeat (2) @(posedge clk);
    chk(dq, 32'h4433_2211);
    chk(32'(doe), 32'h0000_000f);
    apb(1'b1, dcm_pkg::A_DDIR, 32'h0000_0000);
    d_dat <= 32'hd4c3_b2a1;
    repeat (4) @(posedge clk);
    rdc(dcm_pkg::A_DIN, 32'hffff_ffff, 32'hd4c3_b2a1);
    apb(1'b1, dcm_pkg::A_CTRL, 32'h0002_0002);
    d_stp <= 2'h2;
    d_pe <= 2'h1;
    repeat (4) @(posedge clk);
    rdc(dcm_pkg::A_STAT, 32'h0000_003c, 32'h0000_0018);
    apb(1'b1, dcm_pkg::A_CTRL, 32'h0000_0000);
    d_stp <= 2'h1;
    repeat (4) @(posedge clk);
    rdc(dcm_pkg::A_STAT, 32'h0000_00ff, 32'h0000_0040);
    apb(1'b1, dcm_pkg::A_CTRL, 32'h0000_0031);
    repeat (4) @(posedge clk);
    d_lo <= 2'h1;
    wait_run(1'b1);
    tog = 0;
    px = pe[0];
    repeat (40) begin
      @(posedge clk);
      if (pe[0] !== px) tog++;
      px = pe[0];
    end
    chk(32'(tog > 2), 32'h0000_0001);
    d_stp <= 2'h0;
    wait_run(1'b0);
    // opposite edge choices, strobe received rather than driven
    apb(1'b1, dcm_pkg::A_CTRL, 32'h0000_0041);
    repeat (4) @(posedge clk);
    chk(32'(pe_oe), 32'h0000_0000);
    d_lo <= 2'h0;
    wait_run(1'b1);
    d_stp <= 2'h1;
    wait_run(1'b0);
    give_verdict();
  end
endmodule
